// ===== rtl/ecx_ctrl.sv
/*
  extended control logic of a host parallel port: ecr register, mode
  switching, byte fifo with forward/reverse handshake, dma request,
  service and fault interrupts, configuration registers.
  assumes host strobes and dma signals are synchronous to clk; pins
  from the peripheral are asynchronous and synchronised here.
*/
`timescale 1ns/1ps
module ecx_ctrl
  import ecx_pkg::*;
#(
  parameter int DEPTH = ECX_FIFO_DEPTH,
  parameter int AW    = ECX_FIFO_AW
)(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [10:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata_q,
  input  wire logic        dir_req,
  input  wire logic [3:0]  fifo_thr,
  input  wire logic        epp_option,
  input  wire logic [3:0]  irq_sel,
  input  wire logic [1:0]  dma_sel,
  input  wire logic        irq_line_in,
  input  wire logic        dma_ack_n,
  input  wire logic        dma_tc,
  output logic             dma_req_q,
  input  wire logic        fault_in_n,
  input  wire logic        busy_in,
  input  wire logic        ack_in_n,
  input  wire logic [7:0]  pd_in,
  output logic      [7:0]  pd_out_q,
  output logic             pd_oe_q,
  output logic             strobe_out_n_q,
  output logic             auto_feed_out_n_q,
  output logic             ctl_open_coll_q,
  output logic             data_rd_pins_q,
  output logic             dir_q,
  output logic             epp_active_q,
  output logic             irq_out_q,
  output logic             irq_oe_q
);
  // handshake states
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_SET  = 5'b00010,
    HS_STB  = 5'b00100,
    HS_HOLD = 5'b01000,
    HS_RACK = 5'b10000
  } ecx_hs_e;

  ecx_mode_e         mode_q;          // current port mode
  logic              flt_dis_q;       // fault interrupt disable
  logic              dma_en_q;        // dma enable bit
  logic              svc_mask_q;      // service mask
  ecx_hs_e           hs_q;            // peripheral handshake state
  logic [8:0]        mem [DEPTH];     // fifo storage, bit 8 = cmd tag
  logic [AW-1:0]     wp_q;            // write pointer
  logic [AW-1:0]     rp_q;            // read pointer
  logic [AW:0]       cnt_q;           // valid byte count
  logic [7:0]        last_q;          // last byte popped by host
  logic [1:0]        flt_sy_q;        // fault synchroniser
  logic              flt_d_q;         // fault previous level
  logic [1:0]        busy_sy_q;       // busy synchroniser
  logic [1:0]        ack_sy_q;        // ack synchroniser
  logic [7:0]        pd_sy1_q;        // data pins first stage
  logic [7:0]        pd_sy2_q;        // data pins second stage
  logic [1:0]        irl_sy_q;        // shared irq line synchroniser
  logic [7:0]        irq_cnt_q;       // pulse length counter
  logic              rearm_q;         // fault disable cleared, fault low
  logic [AW:0]       thr;             // threshold 1..16
  logic [AW:0]       free_cnt;        // free byte count
  logic              full, empty;     // fifo flags
  logic              fifo_mode;       // modes with a live fifo
  logic              ecr_wr;          // ecr write strobe
  logic              host_push;       // host or dma writes fifo
  logic              host_pop;        // host or dma reads fifo
  logic              hs_push;         // reverse handshake push
  logic              hs_pop;          // forward handshake pop
  logic              push, pop;       // fifo accepted actions
  logic [8:0]        push_word;       // word going in
  logic              mode_ok;         // requested mode change legal
  logic              svc_cond;        // service condition true
  logic              svc_fire;        // service interrupt event
  logic              flt_fire;        // fault interrupt event
  logic              flush;           // discard fifo contents
  logic              fwd_run, rev_run; // handshake allowed
  logic [2:0]        irq_code;        // cfg b irq field
  logic [2:0]        dma_code;        // cfg b dma field

  // decode and fifo flags
  always_comb
  begin
    ecr_wr    = io_wr && io_addr == ECX_OFF_ECR;
    fifo_mode = mode_q inside {ECX_M_CFIF, ECX_M_ECP, ECX_M_TEST};
    full      = cnt_q == (AW+1)'(DEPTH);
    empty     = cnt_q == '0;
    thr       = (AW+1)'(fifo_thr) + 1'b1;
    free_cnt  = (AW+1)'(DEPTH) - cnt_q;
    // dma cycles hit the fifo regardless of address
    host_push = fifo_mode && io_wr &&
                (io_addr == ECX_OFF_FIFO || !dma_ack_n ||
                 (mode_q == ECX_M_ECP && io_addr == ECX_OFF_DATA));
    host_pop  = fifo_mode && io_rd &&
                (io_addr == ECX_OFF_FIFO || !dma_ack_n);
    push_word = {mode_q == ECX_M_ECP && dma_ack_n &&
                 io_addr == ECX_OFF_DATA, io_wdata};
    hs_push   = hs_q == HS_IDLE && rev_run && !ack_sy_q[1] && !full;
    hs_pop    = hs_q == HS_IDLE && fwd_run && !empty && !busy_sy_q[1];
    push      = (host_push || hs_push) && !full;
    pop       = (host_pop || hs_pop) && !empty;
    // mode 000, or reverse ecp ending, discards data
    flush     = mode_q == ECX_M_SPP ||
                (ecr_wr && mode_ok && mode_q == ECX_M_ECP &&
                 dir_q && io_wdata[ECX_B_MODE_HI:ECX_B_MODE_LO] !=
                 3'(ECX_M_ECP));
  end

  // legal mode transitions
  always_comb
  begin
    mode_ok = mode_q == ECX_M_SPP || mode_q == ECX_M_PS2 ||
              io_wdata[ECX_B_MODE_HI:ECX_B_MODE_LO] == 3'(ECX_M_SPP) ||
              io_wdata[ECX_B_MODE_HI:ECX_B_MODE_LO] == 3'(ECX_M_PS2);
  end

  // handshake only runs in transfer modes; test and reserved idle
  always_comb
  begin
    fwd_run = !dir_q &&
              (mode_q == ECX_M_CFIF || mode_q == ECX_M_ECP);
    rev_run = dir_q && mode_q == ECX_M_ECP;
  end

  // service and fault events
  always_comb
  begin
    svc_cond = dma_en_q ? dma_tc
             : (!dir_q ? free_cnt >= thr
                       : cnt_q >= thr);
    svc_fire = fifo_mode && !svc_mask_q && svc_cond;
    flt_fire = mode_q == ECX_M_ECP && !flt_dis_q &&
               ((flt_d_q && !flt_sy_q[1]) || rearm_q);
  end

  // pin synchronisers, two stages each
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flt_sy_q  <= 2'h3;
      flt_d_q   <= 1'b1;
      busy_sy_q <= 2'h0;
      ack_sy_q  <= 2'h3;
      pd_sy1_q  <= 8'h00;
      pd_sy2_q  <= 8'h00;
      irl_sy_q  <= 2'h3;
    end
    else
    begin
      flt_sy_q  <= {flt_sy_q[0], fault_in_n};
      flt_d_q   <= flt_sy_q[1];
      busy_sy_q <= {busy_sy_q[0], busy_in};
      ack_sy_q  <= {ack_sy_q[0], ack_in_n};
      pd_sy1_q  <= pd_in;
      pd_sy2_q  <= pd_sy1_q;
      irl_sy_q  <= {irl_sy_q[0], irq_line_in};
    end
  end

  // ecr control fields
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q    <= ECX_M_SPP;
      flt_dis_q <= ECX_RST_FLT_DIS;
      dma_en_q  <= 1'b0;
      rearm_q   <= 1'b0;
    end
    else
    begin
      rearm_q <= ecr_wr && flt_dis_q && !io_wdata[ECX_B_FLT_DIS] &&
                 !flt_sy_q[1];
      if (ecr_wr)
      begin
        // illegal mode requests keep the old mode
        if (mode_ok)
          mode_q <= ecx_mode_e'(io_wdata[ECX_B_MODE_HI:ECX_B_MODE_LO]);
        flt_dis_q <= io_wdata[ECX_B_FLT_DIS];
        dma_en_q  <= io_wdata[ECX_B_DMA_EN];
      end
    end
  end

  // service mask: hardware set wins over software clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      svc_mask_q <= ECX_RST_SVC_MASK;
    else if (svc_fire)
      svc_mask_q <= 1'b1;
    else if (ecr_wr)
      svc_mask_q <= io_wdata[ECX_B_SVC_MASK];
  end

  // direction follows the request only in mode 001
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dir_q <= 1'b0;
    else if (mode_q == ECX_M_PS2)
      dir_q <= dir_req;
  end

  // fifo storage and pointers
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= hs_push ? {1'b0, pd_sy2_q} : push_word;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // cfg b field encodings
  always_comb
  begin
    case (irq_sel)
      4'hf:    irq_code = 3'h6;
      4'he:    irq_code = 3'h5;
      4'hb:    irq_code = 3'h4;
      4'ha:    irq_code = 3'h3;
      4'h9:    irq_code = 3'h2;
      4'h7:    irq_code = 3'h1;
      4'h5:    irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
    case (dma_sel)
      2'h3:    dma_code = 3'h3;
      2'h2:    dma_code = 3'h2;
      2'h1:    dma_code = 3'h1;
      default: dma_code = 3'h0;
    endcase
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      io_rdata_q <= 8'h00;
      last_q     <= 8'h00;
    end
    else if (io_rd)
    begin
      if (io_addr == ECX_OFF_ECR)
        io_rdata_q <= {3'(mode_q), flt_dis_q, dma_en_q, svc_mask_q,
                       full, empty};
      else if (mode_q == ECX_M_CFG && io_addr == ECX_OFF_FIFO)
        io_rdata_q <= ECX_CFGA_VAL;
      else if (mode_q == ECX_M_CFG && io_addr == ECX_OFF_CFGB)
        io_rdata_q <= {1'b0, irl_sy_q[1], irq_code, dma_code};
      else if (host_pop)
      begin
        // an empty fifo rereads the last byte
        io_rdata_q <= empty ? last_q : mem[rp_q][7:0];
        if (!empty)
          last_q <= mem[rp_q][7:0];
      end
      else
        io_rdata_q <= 8'h00;
    end
  end

  // peripheral handshake engine
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hs_q              <= HS_IDLE;
      pd_out_q          <= 8'h00;
      strobe_out_n_q    <= 1'b1;
      auto_feed_out_n_q <= 1'b1;
    end
    else if (!fwd_run && !rev_run)
    begin
      // mode left: release handshake lines at once
      hs_q              <= HS_IDLE;
      strobe_out_n_q    <= 1'b1;
      auto_feed_out_n_q <= 1'b1;
    end
    else
    begin
      case (hs_q)
        HS_IDLE:
        begin
          if (hs_pop)
          begin
            pd_out_q <= mem[rp_q][7:0];
            // command bytes go with auto feed low
            auto_feed_out_n_q <= !(mode_q == ECX_M_ECP && mem[rp_q][8]);
            hs_q <= HS_SET;
          end
          else if (hs_push)
          begin
            auto_feed_out_n_q <= 1'b0;
            hs_q <= HS_RACK;
          end
        end
        HS_SET:
        begin
          strobe_out_n_q <= 1'b0;
          hs_q <= HS_STB;
        end
        HS_STB:
        begin
          // hold strobe until the peripheral goes busy
          if (busy_sy_q[1])
          begin
            strobe_out_n_q <= 1'b1;
            hs_q <= HS_HOLD;
          end
        end
        HS_HOLD:
        begin
          if (!busy_sy_q[1])
          begin
            auto_feed_out_n_q <= 1'b1;
            hs_q <= HS_IDLE;
          end
        end
        HS_RACK:
        begin
          if (ack_sy_q[1])
          begin
            auto_feed_out_n_q <= 1'b1;
            hs_q <= HS_IDLE;
          end
        end
        default:
          hs_q <= HS_IDLE;
      endcase
    end
  end

  // pin driver modes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pd_oe_q         <= 1'b1;
      ctl_open_coll_q <= 1'b1;
      data_rd_pins_q  <= 1'b0;
      epp_active_q    <= 1'b0;
    end
    else
    begin
      ctl_open_coll_q <= mode_q == ECX_M_SPP;
      pd_oe_q         <= mode_q == ECX_M_SPP || mode_q == ECX_M_CFIF ||
                         !dir_q;
      data_rd_pins_q  <= mode_q == ECX_M_PS2;
      epp_active_q    <= mode_q == ECX_M_EPP && epp_option;
    end
  end

  // dma request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dma_req_q <= 1'b0;
    else
      dma_req_q <= dma_en_q && !svc_mask_q && !svc_fire && fifo_mode &&
                   (dir_q ? cnt_q > (AW+1)'(1) :
                    cnt_q < (AW+1)'(DEPTH - 1));
  end

  // interrupt: short low pulse, then released
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_cnt_q <= 8'h00;
      irq_oe_q  <= 1'b0;
      irq_out_q <= 1'b0;
    end
    else if (svc_fire || flt_fire)
    begin
      irq_cnt_q <= 8'(ECX_IRQ_PULSE_CYC - 1);
      irq_oe_q  <= 1'b1;
    end
    else if (irq_cnt_q != 8'h00)
      irq_cnt_q <= irq_cnt_q - 1'b1;
    else
      irq_oe_q  <= 1'b0;
  end

  // checks
  property p_mode_path;
    @(posedge clk) disable iff (!reset_n)
    $changed(mode_q) |-> ($past(mode_q) inside {ECX_M_SPP, ECX_M_PS2}
                          || mode_q inside {ECX_M_SPP, ECX_M_PS2});
  endproperty
  a_mode_path: assert property (p_mode_path)
    else $error("illegal mode transition");

  property p_svc_masks;
    @(posedge clk) disable iff (!reset_n)
    svc_fire |=> svc_mask_q && irq_oe_q;
  endproperty
  a_svc_masks: assert property (p_svc_masks)
    else $error("service event did not set mask and irq");

  property p_irq_pulse;
    @(posedge clk) disable iff (!reset_n)
    $rose(irq_oe_q) |-> (irq_oe_q && !irq_out_q)[*8];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq pulse too short");

  property p_spp_fifo;
    @(posedge clk) disable iff (!reset_n)
    mode_q == ECX_M_SPP |=> empty ##0 ctl_open_coll_q;
  endproperty
  a_spp_fifo: assert property (p_spp_fifo)
    else $error("spp mode fifo not reset or drivers wrong");

  property p_flags;
    @(posedge clk) disable iff (!reset_n)
    io_rd && io_addr == ECX_OFF_ECR |=>
      io_rdata_q[1:0] == {$past(cnt_q) == (AW+1)'(DEPTH),
                          $past(cnt_q) == '0};
  endproperty
  a_flags: assert property (p_flags)
    else $error("full or empty flag wrong");

  property p_dma_off;
    @(posedge clk) disable iff (!reset_n)
    (!dma_en_q || svc_mask_q) |=> !dma_req_q;
  endproperty
  a_dma_off: assert property (p_dma_off)
    else $error("dma request while disabled or masked");

  property p_fault;
    @(posedge clk) disable iff (!reset_n)
    mode_q == ECX_M_ECP && !flt_dis_q && $fell(flt_sy_q[1]) &&
    !ecr_wr |-> ##[1:2] irq_oe_q;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault edge gave no interrupt");

  property p_rev_stop;
    @(posedge clk) disable iff (!reset_n)
    $past(rev_run) && mode_q != ECX_M_ECP |-> ##1 auto_feed_out_n_q;
  endproperty
  a_rev_stop: assert property (p_rev_stop)
    else $error("auto feed held after leaving reverse ecp");

  property p_test_quiet;
    @(posedge clk) disable iff (!reset_n)
    mode_q == ECX_M_TEST [*2] |-> strobe_out_n_q;
  endproperty
  a_test_quiet: assert property (p_test_quiet)
    else $error("strobe moved in test mode");

  c_fwd_byte: cover property (@(posedge clk) hs_q == HS_HOLD);
  c_rev_byte: cover property (@(posedge clk) hs_q == HS_RACK);
  c_tc_irq:   cover property (@(posedge clk) svc_fire && dma_en_q);
  c_full:     cover property (@(posedge clk) full);
endmodule

// ===== rtl/ecx_pkg.sv
/*
  constants for the extended parallel port control block: offsets,
  ecr field positions, mode codes, fifo size and interrupt pulse timing.
  assumes a single 250 MHz clock and byte-wide host register access.
*/
// What this block does
// - ecr bits 7:5 select port mode
// - bit 4 low enables fault falling-edge irq
// - clearing fault disable while fault low interrupts
// - dma enable bit starts or stops dma
// - service mask blocks dma and service irqs
// - service irq sets mask; software clears it
// - dma terminal count raises service irq
// - output direction free bytes reach threshold irq
// - input direction filled bytes reach threshold irq
// - bits 1,0 report fifo full and empty
// - mode 000 resets fifo, open-collector controls
// - mode 001 direction tristates data, reads pins
// - mode 010 sends fifo by compatibility handshake
// - mode 011 shares fifo, ecp send or receive
// - mode 100 epp only when option enabled
// - mode 110 fifo never handshaked out
// - mode 111 maps config regs at 400h/401h
// - config b encodes irq line and dma
// - mode changes only via 000 or 001
// - entering 010/011 starts automatic handshake
// - leaving reverse ecp drops auto feed, discards
// - ecp input handshakes each byte into fifo
// - interrupt is short low pulse then released
package ecx_pkg;
  // register offsets from the port base
  localparam logic [10:0] ECX_OFF_DATA  = 11'h000; // cmd queue in ecp mode
  localparam logic [10:0] ECX_OFF_FIFO  = 11'h400; // data queue / cfg a
  localparam logic [10:0] ECX_OFF_CFGB  = 11'h401; // cfg b
  localparam logic [10:0] ECX_OFF_ECR   = 11'h402; // extended control
  // ecr field positions
  localparam int ECX_B_MODE_HI  = 7;
  localparam int ECX_B_MODE_LO  = 5;
  localparam int ECX_B_FLT_DIS  = 4;
  localparam int ECX_B_DMA_EN   = 3;
  localparam int ECX_B_SVC_MASK = 2;
  localparam int ECX_B_FULL     = 1;
  localparam int ECX_B_EMPTY    = 0;
  // port modes
  typedef enum logic [2:0] {
    ECX_M_SPP  = 3'h0,
    ECX_M_PS2  = 3'h1,
    ECX_M_CFIF = 3'h2,
    ECX_M_ECP  = 3'h3,
    ECX_M_EPP  = 3'h4,
    ECX_M_RSV  = 3'h5,
    ECX_M_TEST = 3'h6,
    ECX_M_CFG  = 3'h7
  } ecx_mode_e;
  // reset values
  localparam logic       ECX_RST_FLT_DIS  = 1'b1;
  localparam logic       ECX_RST_SVC_MASK = 1'b1;
  localparam logic [7:0] ECX_CFGA_VAL     = 8'h10; // 8-bit implementation
  // fifo geometry
  localparam int ECX_FIFO_DEPTH = 16;
  localparam int ECX_FIFO_AW    = 4;
  // interrupt low pulse length
  localparam int ECX_CLK_PS      = 4000;
  localparam int ECX_IRQ_PULSE_NS = 100;
  localparam int ECX_IRQ_PULSE_CYC =
    (ECX_IRQ_PULSE_NS * 1000) / ECX_CLK_PS;
endpackage

// ===== sim/ecx_periph.sv
/* peripheral model on the far side of the port: takes forward bytes
   with a busy handshake and sends reverse bytes on request.
   assumes the host strobe and auto feed outputs of ecx_ctrl. */
`timescale 1ns/1ps
module ecx_periph (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic       afd_n,
  input  wire logic [7:0] pd_out,
  input  wire logic [3:0] lag,
  output logic            busy,
  output logic            ack_n,
  output logic      [7:0] pd,
  output logic            rx_stb,
  output logic            rx_cmd,
  output logic      [7:0] rx_byte
);
  // idle levels at time zero
  initial
  begin
    {busy, rx_stb, rx_cmd, rx_byte} = '0;
    ack_n = 1'b1;
    pd = 8'ha5;
  end
  // forward: latch byte and its tag on strobe, answer with busy
  always
  begin
    @(negedge strobe_n);
    {rx_cmd, rx_byte} = {~afd_n, pd_out};
    repeat (lag + 1) @(posedge clk);
    #1 {busy, rx_stb} = 2'b11;
    @(posedge strobe_n);
    #1 {busy, rx_stb} = 2'b00;
  end
  // reverse: present byte, clock it with ack, hold ack for lag cycles
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1 pd = b;
    @(posedge clk);
    #1 ack_n = 1'b0;
    for (int k = 0; k < 64 && afd_n; k++) @(posedge clk);
    repeat (lag) @(posedge clk);
    #1 ack_n = 1'b1;
    for (int k = 0; k < 64 && !afd_n; k++) @(posedge clk);
    #1 pd = ~b;
  endtask
endmodule

// ===== sim/testbench.sv
/* self-checking bench for ecx_ctrl: reads, wire bytes and interrupt
   pulses are compared with queued expectations.
   assumes ecx_periph as the peripheral and a 250 MHz clock. */
`timescale 1ns/1ps
module testbench
  import ecx_pkg::*;
;
  logic        clk, reset_n, io_wr, io_rd, dir_req, fault_in_n, rd_d;
  logic        epp_option, irq_line_in, dma_ack_n, dma_tc, busy_in;
  logic        ack_in_n, pd_oe_q, strobe_out_n_q, auto_feed_out_n_q;
  logic        ctl_open_coll_q, irq_out_q, irq_oe_q, rx_stb, rx_cmd;
  logic        dma_req_q, data_rd_pins_q, epp_active_q;
  logic [10:0] io_addr;
  logic [7:0]  io_wdata, io_rdata_q, pd_out_q, pd_per, pd_in, rx_byte;
  logic [7:0]  lfsr;
  logic [3:0]  fifo_thr, irq_sel, lag;
  logic [1:0]  dma_sel;
  logic [8:0]  rd_q[$], pk_q[$];
  logic [7:0]  dq[$];
  int          n_fail, comparisons, irq_len;
  // irq numbers and their cfg b codes
  logic [3:0]  irqs[8] = '{4'hf, 4'he, 4'hb, 4'ha, 4'h9, 4'h7, 4'h5, 4'h3};
  logic [2:0]  icod[8] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h7, 3'h0};
  // device and peripheral model
  ecx_ctrl u_ecx_ctrl (
    .clk, .reset_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata_q,
    .dir_req, .fifo_thr, .epp_option, .irq_sel, .dma_sel, .irq_line_in,
    .dma_ack_n, .dma_tc, .dma_req_q, .fault_in_n, .busy_in, .ack_in_n,
    .pd_in, .pd_out_q, .pd_oe_q, .strobe_out_n_q, .auto_feed_out_n_q,
    .ctl_open_coll_q, .data_rd_pins_q, .dir_q (), .epp_active_q,
    .irq_out_q, .irq_oe_q
  );
  ecx_periph u_ecx_periph (
    .clk, .strobe_n (strobe_out_n_q), .afd_n (auto_feed_out_n_q),
    .pd_out (pd_out_q), .lag, .busy (busy_in), .ack_n (ack_in_n),
    .pd (pd_per), .rx_stb, .rx_cmd, .rx_byte
  );
  // data wire: host drives when enabled, else the peripheral
  assign pd_in = pd_oe_q ? pd_out_q : pd_per;
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pseudo-random byte source
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // compare and count
  task automatic chk(input string nm, input logic [8:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one register write
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(posedge clk);
    #1 io_wr = 1'b0;
  endtask
  // one register read, expectation noted first
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    rd_q.push_back({1'b0, e});
    @(posedge clk);
    #1 {io_addr, io_rd} = {a, 1'b1};
    @(posedge clk);
    #1 io_rd = 1'b0;
  endtask
  // bounded wait for all noted wire bytes
  task automatic drain();
    for (int k = 0; k < 800 && pk_q.size() > 0; k++) @(posedge clk);
    #1;
    chk("left", pk_q.size(), 0);
  endtask
  // bounded wait for an interrupt pulse, then let it finish
  task automatic wait_irq(input logic e);
    for (int k = 0; k < 40 && !irq_oe_q; k++) @(posedge clk);
    chk("irq", irq_oe_q, e);
    chk("irq_lvl", irq_out_q, 0);
    repeat (30) @(posedge clk);
    #1;
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // read data one cycle after the strobe; pulse length timing
  always @(posedge clk)
  begin
    rd_d <= io_rd;
    if (rd_d)
      chk("rdata", {1'b0, io_rdata_q}, rd_q.pop_front());
    irq_len <= irq_oe_q ? irq_len + 1 : 0;
    if (!irq_oe_q && irq_len != 0)
      chk("pulse", irq_len, ECX_IRQ_PULSE_CYC);
  end
  // bytes seen by the peripheral
  always @(posedge rx_stb)
    chk("wire", {rx_cmd, rx_byte}, pk_q.pop_front());
  // hang guard
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    conclude();
  end
  // main sequence
  initial
  begin
    {reset_n, io_wr, io_rd, dir_req, epp_option, irq_line_in} = '0;
    {fault_in_n, dma_ack_n, dma_tc, io_addr, io_wdata} = 22'h300000;
    {fifo_thr, irq_sel, dma_sel, lag} = '0;
    lfsr = 8'h1f;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    lfsr = nxt(lfsr);
    fifo_thr = lfsr[3:0];
    rd(ECX_OFF_ECR, 8'h15);
    chk("open_coll", ctl_open_coll_q, 1);
    $display("test reset done");
    wr(ECX_OFF_ECR, 8'hf4);
    rd(ECX_OFF_FIFO, ECX_CFGA_VAL);
    for (int k = 0; k < 8; k++)
    begin
      {irq_sel, dma_sel} = {irqs[k], 2'(k)};
      rd(ECX_OFF_CFGB, {2'b00, icod[k], 1'b0, 2'(k)});
    end
    wr(ECX_OFF_ECR, 8'h54);
    rd(ECX_OFF_ECR, 8'hf5);
    $display("test config done");
    wr(ECX_OFF_ECR, 8'h34);
    wr(ECX_OFF_ECR, 8'hd4);
    for (int k = 0; k < 17; k++)
    begin
      lfsr = nxt(lfsr);
      dq.push_back(lfsr);
      wr(ECX_OFF_FIFO, lfsr);
    end
    chk("strobe", strobe_out_n_q, 1);
    chk("open_coll", ctl_open_coll_q, 0);
    rd(ECX_OFF_ECR, 8'hd6);
    for (int k = 0; k < 17; k++)
      rd(ECX_OFF_FIFO, dq[k < 16 ? k : 15]);
    rd(ECX_OFF_ECR, 8'hd5);
    wr(ECX_OFF_ECR, 8'hd4);
    wait_irq(0);
    wr(ECX_OFF_ECR, 8'hd0);
    wait_irq(1);
    rd(ECX_OFF_ECR, 8'hd5);
    wr(ECX_OFF_ECR, 8'h34);
    dir_req = 1'b1;
    wr(ECX_OFF_ECR, 8'hd0);
    for (int k = 0; k < fifo_thr; k++)
      wr(ECX_OFF_FIFO, 8'(k));
    wait_irq(0);
    wr(ECX_OFF_FIFO, 8'h77);
    wait_irq(1);
    wr(ECX_OFF_ECR, 8'h34);
    dir_req = 1'b0;
    wr(ECX_OFF_ECR, 8'h14);
    $display("test fifo done");
    lag = {2'b00, lfsr[1:0]};
    wr(ECX_OFF_ECR, 8'h54);
    for (int k = 0; k < 4; k++)
    begin
      lfsr = nxt(lfsr);
      pk_q.push_back({1'b0, lfsr});
      wr(ECX_OFF_FIFO, lfsr);
    end
    drain();
    wr(ECX_OFF_ECR, 8'h14);
    wr(ECX_OFF_ECR, 8'h74);
    pk_q.push_back(9'h1c3);
    wr(ECX_OFF_DATA, 8'hc3);
    pk_q.push_back(9'h03c);
    wr(ECX_OFF_FIFO, 8'h3c);
    drain();
    $display("test forward done");
    fault_in_n = 1'b0;
    // let the fault settle while still disabled, then clear the disable
    repeat (4) @(posedge clk);
    wr(ECX_OFF_ECR, 8'h64);
    wait_irq(1);
    fault_in_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 fault_in_n = 1'b0;
    wait_irq(1);
    fault_in_n = 1'b1;
    wr(ECX_OFF_ECR, 8'h74);
    fault_in_n = 1'b0;
    wait_irq(0);
    fault_in_n = 1'b1;
    $display("test fault done");
    wr(ECX_OFF_ECR, 8'h34);
    dir_req = 1'b1;
    wr(ECX_OFF_ECR, 8'h74);
    lfsr = nxt(lfsr);
    u_ecx_periph.send(lfsr);
    rd(ECX_OFF_FIFO, lfsr);
    lag = 4'h8;
    fork
      u_ecx_periph.send(8'h96);
    join_none
    for (int k = 0; k < 40 && auto_feed_out_n_q; k++) @(posedge clk);
    chk("feed_lo", auto_feed_out_n_q, 0);
    wr(ECX_OFF_ECR, 8'h34);
    @(posedge clk);
    #1 chk("feed_hi", auto_feed_out_n_q, 1);
    repeat (20) @(posedge clk);
    #1 chk("oe", pd_oe_q, 0);
    chk("pins", data_rd_pins_q, 1);
    $display("test reverse done");
    // dma: request while enabled, terminal count interrupts
    dir_req = 1'b0;
    wr(ECX_OFF_ECR, 8'hd8);
    repeat (2) @(posedge clk);
    #1 chk("dreq", dma_req_q, 1);
    dma_tc = 1'b1;
    @(posedge clk);
    #1 dma_tc = 1'b0;
    wait_irq(1);
    chk("dreq_off", dma_req_q, 0);
    // epp flag follows the option; reserved mode stays idle
    wr(ECX_OFF_ECR, 8'h34);
    wr(ECX_OFF_ECR, 8'h94);
    @(posedge clk);
    #1 chk("epp_off", epp_active_q, 0);
    epp_option = 1'b1;
    @(posedge clk);
    #1 chk("epp_on", epp_active_q, 1);
    wr(ECX_OFF_ECR, 8'h34);
    wr(ECX_OFF_ECR, 8'hb4);
    rd(ECX_OFF_ECR, 8'hb5);
    chk("rsv_pp", ctl_open_coll_q, 0);
    chk("rsv_stb", strobe_out_n_q, 1);
    $display("test modes done");
    conclude();
  end
endmodule
